// ### vid_slew_consts.svh
`ifndef VID_SLEW_CONSTS_SVH
`define VID_SLEW_CONSTS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define OFS_CODE0       8'h00
`define OFS_CODE1       8'h04
`define OFS_CODE2       8'h08
`define OFS_CTRL        8'h0c
`define OFS_SLEW_TIMING_RESISTOR       8'h10
`define OFS_LIMITS      8'h14
`define OFS_STATE       8'h18
`define OFS_IRQ_STATUS  8'h1c
`define OFS_IRQ_ENABLE  8'h20
`define OFS_IRQ_CLEAR   8'h24

// ************************************************************
// Field positions
// ************************************************************
`define CTRL_ENABLE_BIT   0
`define CTRL_BOOT_DONE    1
`define CTRL_COMBINED     2
`define CTRL_LPS_LSB      4
`define LIMITS_NB_LSB     8

// ************************************************************
// Reset values
// ************************************************************
`define RST_CODE        7'h7f
`define RST_CTRL        7'h00
`define RST_SLEW_TIMING_RESISTOR       12'h08f
`define RST_LIMITS      16'h0000
`define RST_IRQ_ENABLE  6'h00

// ************************************************************
// Timing and scaling
// ************************************************************
`define CLK_PERIOD_NS   20
`define PG_REEN_NS      20000
`define PG_REEN_CYC     ((`PG_REEN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Slew rate 6.25 mV/us x 143 kohm / R, target step 0.5 mV
`define SLEW_RATE_UV_US 6250
`define SLEW_R_KOHM     143
`define STEP_UV         500
`define SLEW_NUM        (`SLEW_RATE_UV_US * `SLEW_R_KOHM * 10 * `CLK_PERIOD_NS / (`STEP_UV * 1000 / 2))
`define SOFT_RATE_UV_US 1000
`define SOFT_DEN        (`SLEW_NUM * `STEP_UV * 1000 / (`SOFT_RATE_UV_US * `CLK_PERIOD_NS))
`define SLEW_TIMING_RESISTOR_MIN       12'd357
`define SLEW_TIMING_RESISTOR_MAX       12'd3570
`define FULL_UNITS      12'd3100
`define CODE_UNITS      12'd25
`define CODE_OFF        7'h7c
`define CORE_IDLE_PCT   15
`define NB_IDLE_PCT     25

`endif

// ### vid_slew_pkg.sv
package vid_slew_pkg;
  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_SLEW_UP = 3'b001,
    ST_SLEW_DN = 3'b010,
    ST_HOLD_UP = 3'b011,
    ST_WAIT_RG = 3'b100,
    ST_STEADY  = 3'b101
  } slew_state_e;
  typedef logic [6:0] vid_code_t;
endpackage

// ### vid_slew_ctrl.sv
// Notes on behaviour
// - Slew rate follows timing resistor, 25..2.5mV/us
// - Transition start blanks both power-good thresholds
// - Upward: thresholds back 20us after settling
// - Downward: upper threshold back once output arrives
// - Linear slew at 6.25mV/us x 143k/R
// - Soft-start ramps at fixed 1mV/us
// - Shutdown turns on discharge switches
// - After boot, select bit 1: forced-PWM
// - Soft-start or select bit 0: pulse-skipping
// - Skip on-time ends on feedback and idle current
// - Downward: overvoltage threshold held at 1.85V
// - Mode chosen per output from own bit, except output 1 uses bit 0 when combined
// - Combined core: 1-phase skip, 2-phase PWM
// - Skip mode: no on-time while output high
// - Three independent 7-bit voltage codes
// - Downward skip transition disables DC integrator
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`include "vid_slew_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module vid_slew_ctrl
#(
  parameter int NOUT = 3
)
(
  input  wire logic                    I_CLK,
  input  wire logic                    I_RESETN,
  input  wire logic [3:0]              I_AVS_ADDRESS,
  input  wire logic                    I_AVS_READ,
  input  wire logic                    I_AVS_WRITE,
  input  wire logic [31:0]             I_AVS_WRITEDATA,
  output logic [31:0]                  O_AVS_READDATA,
  output logic                         O_AVS_WAITREQUEST,
  input  wire logic [NOUT-1:0]         I_FB_ABOVE,
  input  wire logic [NOUT-1:0]         I_CS_ABOVE_IDLE,
  input  wire logic [NOUT-1:0]         I_ZERO_CROSS,
  input  wire logic [NOUT-1:0]         I_SW_CLK,
  input  wire logic [NOUT-1:0]         I_IN_REG,
  input  wire logic [NOUT-1:0]         I_ERR_CMP,
  input  wire logic [NOUT-1:0]         I_PG_UPPER_OK,
  input  wire logic [NOUT-1:0]         I_PG_LOWER_OK,
  output logic [NOUT-1:0]              O_HIGH_SIDE_GATE,
  output logic [NOUT-1:0]              O_LOW_SIDE_GATE_DRIVE,
  output logic [NOUT-1:0]              O_ZC_ENABLE,
  output logic [NOUT-1:0]              O_INTEGRATOR_EN,
  output logic [NOUT-1:0]              O_OVP_HOLD_1V85,
  output logic [NOUT*12-1:0]           O_TARGET,
  output logic                         O_CORE_TWO_PHASE,
  output logic [1:0]                   O_DISCHARGE_CORE,
  output logic                         O_DISCHARGE_NB,
  output logic [7:0]                   O_CORE_IDLE_THRESH,
  output logic [7:0]                   O_NB_IDLE_THRESH,
  output logic                         O_POWER_GOOD_OUTPUT_O,
  output logic                         O_POWER_GOOD_OUTPUT_OE,
  output logic                         O_IRQ
);
  import vid_slew_pkg::*;

  localparam int NSYNC = 8 * NOUT;
  localparam logic [14:0] SLEW_NUM = 15'(`SLEW_NUM);
  localparam logic [14:0] SOFT_DEN = 15'(`SOFT_DEN);
  localparam logic [9:0]  PG_REEN  = 10'(`PG_REEN_CYC);

  function automatic logic [11:0] code_units(input logic [6:0] code);
    logic [11:0] u;
    u = `FULL_UNITS - 12'(code * `CODE_UNITS);
    code_units = (code >= `CODE_OFF) ? 12'h000 : u;
  endfunction

  // ************************************************************
  // Pin input filtering
  // ************************************************************
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;
  logic [NSYNC-1:0] s3_r;
  logic [NSYNC-1:0] filt_r;
  logic [NSYNC-1:0] filt_d_r;

  assign pin_raw = {I_PG_LOWER_OK, I_PG_UPPER_OK, I_ERR_CMP, I_IN_REG,
                    I_SW_CLK, I_ZERO_CROSS, I_CS_ABOVE_IDLE, I_FB_ABOVE};

  genvar gb;
  generate
    for (gb = 0; gb < NSYNC; gb++)
    begin : g_sync
      always_ff @(posedge I_CLK or negedge I_RESETN)
      begin
        if (!I_RESETN)
        begin
          s1_r[gb]     <= 1'b0;
          s2_r[gb]     <= 1'b0;
          s3_r[gb]     <= 1'b0;
          filt_r[gb]   <= 1'b0;
          filt_d_r[gb] <= 1'b0;
        end
        else
        begin
          s1_r[gb]     <= pin_raw[gb];
          s2_r[gb]     <= s1_r[gb];
          s3_r[gb]     <= s2_r[gb];
          filt_r[gb]   <= (s2_r[gb] == s3_r[gb]) ? s3_r[gb] : filt_r[gb];
          filt_d_r[gb] <= filt_r[gb];
        end
      end
    end
  endgenerate

  wire [NOUT-1:0] fb_above = filt_r[0*NOUT +: NOUT];
  wire [NOUT-1:0] cs_idle  = filt_r[1*NOUT +: NOUT];
  wire [NOUT-1:0] zcross   = filt_r[2*NOUT +: NOUT];
  wire [NOUT-1:0] swclk_rise = filt_r[3*NOUT +: NOUT] & ~filt_d_r[3*NOUT +: NOUT];
  wire [NOUT-1:0] in_reg   = filt_r[4*NOUT +: NOUT];
  wire [NOUT-1:0] err_edge = filt_r[5*NOUT +: NOUT] ^ filt_d_r[5*NOUT +: NOUT];
  wire [NOUT-1:0] pg_hi_ok = filt_r[6*NOUT +: NOUT];
  wire [NOUT-1:0] pg_lo_ok = filt_r[7*NOUT +: NOUT];

  // ************************************************************
  // Bus slave and registers
  // ************************************************************
  logic             ack_r;
  logic [31:0]      rdata_r;
  vid_code_t        code_r [NOUT];
  logic [6:0]       ctrl_r;
  logic [11:0]      slew_timing_resistor_r;
  logic [15:0]      limits_r;
  logic [2*NOUT-1:0] irq_stat_r;
  logic [2*NOUT-1:0] irq_en_r;
  logic [2*NOUT-1:0] irq_evt;
  logic [6*NOUT-1:0] state_word;
  logic [31:0]      rd_mux;

  wire        req      = I_AVS_READ | I_AVS_WRITE;
  wire        wr_take  = I_AVS_WRITE & ack_r;
  wire [7:0]  byte_adr = {2'b00, I_AVS_ADDRESS, 2'b00};
  wire        wr_clear = wr_take & (byte_adr == `OFS_IRQ_CLEAR);
  wire        enable   = ctrl_r[`CTRL_ENABLE_BIT];
  wire        boot_done = ctrl_r[`CTRL_BOOT_DONE];
  wire        combined = ctrl_r[`CTRL_COMBINED];
  wire [2:0]  lps      = ctrl_r[`CTRL_LPS_LSB +: 3];

  assign O_AVS_WAITREQUEST = req & ~ack_r;
  assign O_AVS_READDATA    = rdata_r;

  assign rd_mux =
    (byte_adr == `OFS_CODE0)      ? {25'h0, code_r[0]} :
    (byte_adr == `OFS_CODE1)      ? {25'h0, code_r[1]} :
    (byte_adr == `OFS_CODE2)      ? {25'h0, code_r[2]} :
    (byte_adr == `OFS_CTRL)       ? {25'h0, ctrl_r} :
    (byte_adr == `OFS_SLEW_TIMING_RESISTOR)      ? {20'h0, slew_timing_resistor_r} :
    (byte_adr == `OFS_LIMITS)     ? {16'h0, limits_r} :
    (byte_adr == `OFS_STATE)      ? {14'h0, state_word} :
    (byte_adr == `OFS_IRQ_STATUS) ? {26'h0, irq_stat_r} :
    (byte_adr == `OFS_IRQ_ENABLE) ? {26'h0, irq_en_r} : 32'h0;

  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0;
    end
    else
    begin
      ack_r   <= req & ~ack_r;
      rdata_r <= (I_AVS_READ & ~ack_r) ? rd_mux : rdata_r;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      ctrl_r   <= `RST_CTRL;
      slew_timing_resistor_r  <= `RST_SLEW_TIMING_RESISTOR;
      limits_r <= `RST_LIMITS;
      irq_en_r <= `RST_IRQ_ENABLE;
    end
    else if (wr_take)
    begin
      ctrl_r   <= (byte_adr == `OFS_CTRL) ? I_AVS_WRITEDATA[6:0] : ctrl_r;
      slew_timing_resistor_r  <= (byte_adr == `OFS_SLEW_TIMING_RESISTOR) ? I_AVS_WRITEDATA[11:0] : slew_timing_resistor_r;
      limits_r <= (byte_adr == `OFS_LIMITS) ? I_AVS_WRITEDATA[15:0] : limits_r;
      irq_en_r <= (byte_adr == `OFS_IRQ_ENABLE) ? I_AVS_WRITEDATA[5:0] : irq_en_r;
    end
  end

  // Event set wins over a clear in the same cycle
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
      irq_stat_r <= '0;
    else
      irq_stat_r <= irq_evt | (irq_stat_r & ~(wr_clear ? I_AVS_WRITEDATA[5:0] : 6'h0));
  end

  assign O_IRQ = |(irq_stat_r & irq_en_r);

  assign O_CORE_IDLE_THRESH = 8'((16'(limits_r[7:0]) * 16'(`CORE_IDLE_PCT)) / 16'd100);
  assign O_NB_IDLE_THRESH   = 8'((16'(limits_r[15:8]) * 16'(`NB_IDLE_PCT)) / 16'd100);

  wire [11:0] slew_timing_resistor_cl = (slew_timing_resistor_r < `SLEW_TIMING_RESISTOR_MIN) ? `SLEW_TIMING_RESISTOR_MIN :
                         (slew_timing_resistor_r > `SLEW_TIMING_RESISTOR_MAX) ? `SLEW_TIMING_RESISTOR_MAX : slew_timing_resistor_r;
  wire [14:0] slew_den = {2'b00, slew_timing_resistor_cl, 1'b0};

  assign O_DISCHARGE_CORE = {2{~enable}};
  assign O_DISCHARGE_NB   = ~enable;

  logic [NOUT-1:0] pwm_mode;
  logic [NOUT-1:0] pg_hi_r;
  logic [NOUT-1:0] pg_lo_r;

  assign O_CORE_TWO_PHASE = combined & pwm_mode[0];

  wire pg_all = &(pg_hi_r & pg_lo_r);
  assign O_POWER_GOOD_OUTPUT_O  = 1'b0;
  assign O_POWER_GOOD_OUTPUT_OE = ~pg_all;

  // ************************************************************
  // Per-output slew, blanking and gate control
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NOUT; gi++)
    begin : g_out
      slew_state_e st_r;
      logic [11:0] tgt_r;
      logic [14:0] acc_r;
      logic [9:0]  hold_r;
      logic        soft_r;
      logic        blank_hi_r;
      logic        blank_lo_r;
      logic        ovp_r;
      logic        integ_off_r;
      logic        on_r;
      logic        zc_r;
      logic        hi_r;
      logic        lo_r;
      logic        en_d_r;
      logic        pg_d_r;

      wire        lps_eff = (gi == 1 && combined) ? lps[0] : lps[gi];
      wire        phase_off = (gi == 1) && combined && !pwm_mode[0];
      wire        code_wr = wr_take && (byte_adr == 8'(4 * gi));
      wire [11:0] fin = code_units(code_r[gi]);
      wire [14:0] den = soft_r ? SOFT_DEN : slew_den;
      wire [14:0] acc_sum = acc_r + SLEW_NUM;
      wire        tick = acc_sum >= den;
      wire        start = enable & ~en_d_r;
      wire        chg = code_wr & (I_AVS_WRITEDATA[6:0] != code_r[gi]);
      wire        at_fin = (tgt_r == fin);
      wire        slewing = (st_r == ST_SLEW_UP) || (st_r == ST_SLEW_DN);
      wire        skip = ~pwm_mode[gi];
      wire        on_nxt;
      wire        zc_nxt;

      assign pwm_mode[gi] = boot_done & lps_eff & ~soft_r;

      always_ff @(posedge I_CLK or negedge I_RESETN)
      begin
        if (!I_RESETN)
          code_r[gi] <= `RST_CODE;
        else if (code_wr)
          code_r[gi] <= I_AVS_WRITEDATA[6:0];
      end

      always_ff @(posedge I_CLK or negedge I_RESETN)
      begin
        if (!I_RESETN)
          en_d_r <= 1'b0;
        else
          en_d_r <= enable;
      end

      always_ff @(posedge I_CLK or negedge I_RESETN)
      begin
        if (!I_RESETN)
          acc_r <= '0;
        else if (!slewing)
          acc_r <= '0;
        else
          acc_r <= tick ? 15'(acc_sum - den) : acc_sum;
      end

      // Slew state machine
      always_ff @(posedge I_CLK or negedge I_RESETN)
      begin
        if (!I_RESETN)
        begin
          st_r   <= ST_OFF;
          tgt_r  <= '0;
          soft_r <= 1'b0;
          hold_r <= '0;
        end
        else if (!enable)
        begin
          st_r   <= ST_OFF;
          tgt_r  <= '0;
          soft_r <= 1'b0;
        end
        else if (start)
        begin
          st_r   <= ST_SLEW_UP;
          tgt_r  <= '0;
          soft_r <= 1'b1;
        end
        else if (chg)
        begin
          st_r <= (code_units(I_AVS_WRITEDATA[6:0]) >= tgt_r) ? ST_SLEW_UP : ST_SLEW_DN;
        end
        else
        begin
          case (st_r)
            ST_SLEW_UP:
            begin
              if (tgt_r > fin)
                st_r <= ST_SLEW_DN;
              else if (at_fin)
              begin
                st_r   <= ST_HOLD_UP;
                hold_r <= '0;
                soft_r <= 1'b0;
              end
              else if (tick)
                tgt_r <= tgt_r + 12'd1;
            end
            ST_SLEW_DN:
            begin
              if (tgt_r < fin)
                st_r <= ST_SLEW_UP;
              else if (at_fin)
                st_r <= ST_WAIT_RG;
              else if (tick)
                tgt_r <= tgt_r - 12'd1;
            end
            ST_HOLD_UP:
            begin
              hold_r <= hold_r + 10'd1;
              if (hold_r == PG_REEN - 10'd1)
                st_r <= ST_STEADY;
            end
            ST_WAIT_RG:
              st_r <= in_reg[gi] ? ST_STEADY : ST_WAIT_RG;
            ST_STEADY:
              st_r <= ST_STEADY;
            default:
              st_r <= ST_OFF;
          endcase
        end
      end

      always_ff @(posedge I_CLK or negedge I_RESETN)
      begin
        if (!I_RESETN)
        begin
          blank_hi_r <= 1'b1;
          blank_lo_r <= 1'b1;
        end
        else if (start || chg || !enable)
        begin
          blank_hi_r <= 1'b1;
          blank_lo_r <= 1'b1;
        end
        else
        begin
          blank_hi_r <= blank_hi_r & ~(st_r == ST_STEADY);
          blank_lo_r <= blank_lo_r & ~((st_r == ST_STEADY) || (st_r == ST_WAIT_RG));
        end
      end

      always_ff @(posedge I_CLK or negedge I_RESETN)
      begin
        if (!I_RESETN)
        begin
          ovp_r       <= 1'b0;
          integ_off_r <= 1'b0;
        end
        else if (chg && code_units(I_AVS_WRITEDATA[6:0]) < tgt_r)
        begin
          ovp_r       <= 1'b1;
          integ_off_r <= skip;
        end
        else
        begin
          ovp_r       <= ovp_r & ~((st_r == ST_WAIT_RG) && in_reg[gi]);
          integ_off_r <= integ_off_r & ~(!slewing && err_edge[gi]);
        end
      end

      always_ff @(posedge I_CLK or negedge I_RESETN)
      begin
        if (!I_RESETN)
        begin
          pg_hi_r[gi] <= 1'b0;
          pg_lo_r[gi] <= 1'b0;
          pg_d_r      <= 1'b0;
        end
        else
        begin
          pg_hi_r[gi] <= blank_hi_r ? pg_hi_r[gi] : pg_hi_ok[gi];
          pg_lo_r[gi] <= blank_lo_r ? pg_lo_r[gi] : pg_lo_ok[gi];
          pg_d_r      <= pg_hi_r[gi] & pg_lo_r[gi];
        end
      end

      assign on_nxt = (swclk_rise[gi] && enable && !phase_off && !(skip && fb_above[gi])) ? 1'b1 :
                      (on_r && fb_above[gi] && (pwm_mode[gi] || cs_idle[gi])) ? 1'b0 :
                      on_r & enable & ~phase_off;
      assign zc_nxt = on_nxt ? 1'b0 : (zc_r | zcross[gi]);

      always_ff @(posedge I_CLK or negedge I_RESETN)
      begin
        if (!I_RESETN)
        begin
          on_r <= 1'b0;
          zc_r <= 1'b0;
          hi_r <= 1'b0;
          lo_r <= 1'b0;
        end
        else
        begin
          on_r <= on_nxt;
          zc_r <= zc_nxt;
          hi_r <= on_nxt;
          // complement in PWM, cut at zero current
          lo_r <= enable & ~phase_off & ~on_nxt & ~(skip & zc_nxt);
        end
      end

      assign O_HIGH_SIDE_GATE[gi]      = hi_r;
      assign O_LOW_SIDE_GATE_DRIVE[gi] = lo_r;
      assign O_ZC_ENABLE[gi]           = skip;
      assign O_INTEGRATOR_EN[gi]       = ~integ_off_r;
      assign O_OVP_HOLD_1V85[gi]       = ovp_r;
      assign O_TARGET[gi*12 +: 12]     = tgt_r;
      assign irq_evt[gi]        = slewing & at_fin & ~chg;
      assign irq_evt[NOUT + gi] = pg_d_r & ~(pg_hi_r[gi] & pg_lo_r[gi]);
      assign state_word[gi*6 +: 6] = {pg_hi_r[gi] & pg_lo_r[gi], slewing, pwm_mode[gi],
                                      integ_off_r, ovp_r, blank_hi_r};
    end
  endgenerate

endmodule
`default_nettype wire

// ### vid_slew_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module vid_slew_ctrl_chk
#(
  parameter int NOUT = 3
)
(
  input wire logic                I_CLK,
  input wire logic                I_RESETN,
  input wire logic [3:0]          I_AVS_ADDRESS,
  input wire logic                I_AVS_READ,
  input wire logic                I_AVS_WRITE,
  input wire logic [31:0]         I_AVS_WRITEDATA,
  input wire logic                O_AVS_WAITREQUEST,
  input wire logic [NOUT-1:0]     O_HIGH_SIDE_GATE,
  input wire logic [NOUT-1:0]     O_LOW_SIDE_GATE_DRIVE,
  input wire logic [NOUT-1:0]     O_ZC_ENABLE,
  input wire logic [NOUT-1:0]     O_OVP_HOLD_1V85,
  input wire logic [NOUT*12-1:0]  O_TARGET,
  input wire logic                O_CORE_TWO_PHASE,
  input wire logic [1:0]          O_DISCHARGE_CORE,
  input wire logic                O_DISCHARGE_NB,
  input wire logic [7:0]          O_CORE_IDLE_THRESH,
  input wire logic [7:0]          O_NB_IDLE_THRESH
);
  // ****************************
  // Accepted writes
  // ****************************
  wire logic        wr_ok = I_AVS_WRITE & ~O_AVS_WAITREQUEST;
  wire logic        wr_lim = wr_ok && (I_AVS_ADDRESS == 4'h5);
  wire logic        wr_ctl = wr_ok && (I_AVS_ADDRESS == 4'h3);
  wire logic [11:0] tgt0 = O_TARGET[11:0];
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);

  AST_BUS_ONE_WAIT:
    assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
    else $error("more than one wait state");
  AST_CORE_IDLE:
    assert property (wr_lim |=> O_CORE_IDLE_THRESH == ($past(I_AVS_WRITEDATA[7:0]) * 15) / 100)
    else $error("core idle threshold wrong");
  AST_NB_IDLE:
    assert property (wr_lim |=> O_NB_IDLE_THRESH == ($past(I_AVS_WRITEDATA[15:8]) * 25) / 100)
    else $error("nb idle threshold wrong");
  AST_DISCHARGE:
    assert property (wr_ctl |=> O_DISCHARGE_NB == !$past(I_AVS_WRITEDATA[0])
      && O_DISCHARGE_CORE == {2{O_DISCHARGE_NB}})
    else $error("discharge switches wrong");
  AST_PWM_COMPL:
    assert property (!O_ZC_ENABLE[2] && !$past(O_ZC_ENABLE[2]) && !O_DISCHARGE_NB && !$past(O_DISCHARGE_NB)
      |-> O_LOW_SIDE_GATE_DRIVE[2] == !O_HIGH_SIDE_GATE[2])
    else $error("low gate not complement in pwm");
  AST_TWO_PHASE:
    assert property (O_CORE_TWO_PHASE |-> !O_ZC_ENABLE[0])
    else $error("two phase while skipping");
  AST_TARGET_UNIT:
    assert property ($changed(tgt0) && !O_DISCHARGE_NB && !$past(O_DISCHARGE_NB)
      |-> (tgt0 == 12'($past(tgt0) + 12'h001)) || (12'(tgt0 + 12'h001) == $past(tgt0)))
    else $error("target jumped");
  AST_SKIP_ZC:
    assert property (wr_ctl && !I_AVS_WRITEDATA[6] |-> ##[1:2] O_ZC_ENABLE[2])
    else $error("skip mode without zero cross");

  COV_TWO_PHASE: cover property (O_CORE_TWO_PHASE);
  COV_OVP_HOLD: cover property ($rose(O_OVP_HOLD_1V85[0]));
  COV_PWM: cover property (!O_ZC_ENABLE[2] && O_HIGH_SIDE_GATE[2]);
endmodule

bind vid_slew_ctrl vid_slew_ctrl_chk #(.NOUT(NOUT)) u_chk
(
  .I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_AVS_ADDRESS(I_AVS_ADDRESS),
  .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
  .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_HIGH_SIDE_GATE(O_HIGH_SIDE_GATE),
  .O_LOW_SIDE_GATE_DRIVE(O_LOW_SIDE_GATE_DRIVE), .O_ZC_ENABLE(O_ZC_ENABLE),
  .O_OVP_HOLD_1V85(O_OVP_HOLD_1V85), .O_TARGET(O_TARGET), .O_CORE_TWO_PHASE(O_CORE_TWO_PHASE),
  .O_DISCHARGE_CORE(O_DISCHARGE_CORE), .O_DISCHARGE_NB(O_DISCHARGE_NB),
  .O_CORE_IDLE_THRESH(O_CORE_IDLE_THRESH), .O_NB_IDLE_THRESH(O_NB_IDLE_THRESH)
);
`default_nettype wire

// ### vid_plant.sv
`timescale 1ns/1ps
`default_nettype none
module vid_plant
#(
  parameter int SW_DIV = 16
)
(
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic [2:0] i_high_gate,
  output logic [2:0]      o_sw_clk,
  output logic [2:0]      o_fb_above,
  output logic [2:0]      o_cs_idle,
  output logic [2:0]      o_zero_cross,
  output logic [2:0]      o_err_cmp,
  output logic [2:0]      o_pg_ok
);
  logic [7:0] div_r;
  logic [3:0] v_r [3];
  // ****************************
  // Crude output stage
  // ****************************
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      div_r <= 8'h00;
      v_r <= '{default: 4'h0};
    end
    else
    begin
      div_r <= (div_r == 8'(SW_DIV - 1)) ? 8'h00 : div_r + 8'h01;
      for (int i = 0; i < 3; i++)
        v_r[i] <= i_high_gate[i] ? ((v_r[i] == 4'hf) ? v_r[i] : v_r[i] + 4'h1)
                                 : ((v_r[i] == 4'h0) ? v_r[i] : v_r[i] - 4'h1);
    end
  end
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      o_fb_above[i] = v_r[i] > 4'h8;
      o_cs_idle[i] = v_r[i] > 4'h4;
      o_zero_cross[i] = v_r[i] == 4'h0;
    end
  end
  assign o_sw_clk = {3{div_r < 8'(SW_DIV / 2)}};
  assign o_err_cmp = o_fb_above;
  assign o_pg_ok = 3'b111;
endmodule
`default_nettype wire

// ### test_vid_slew_and_skip_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_vid_slew_and_skip_mode_control;
  import vid_slew_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [2:0]  in_reg = 3'h0;
  logic [31:0] seed = 32'he48a7fc4;
  logic [31:0] d;
  logic [31:0] v;
  int          n_errors = 0;
  int          checks = 0;
  int          cyc;
  wire [31:0]  rdata;
  wire [35:0]  target;
  wire [2:0]   fb, csi, zc, swc, errc, pgok, hs, ls, zce, integ, ovp;
  wire [1:0]   dis_core;
  wire [7:0]   core_th, nb_th;
  wire         waitreq, two_ph, dis_nb, pg_o, pg_oe, irq;

  always #10 clk = ~clk;

  vid_slew_ctrl i_dut (.I_CLK(clk), .I_RESETN(resetn), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
    .I_FB_ABOVE(fb), .I_CS_ABOVE_IDLE(csi), .I_ZERO_CROSS(zc), .I_SW_CLK(swc), .I_IN_REG(in_reg),
    .I_ERR_CMP(errc), .I_PG_UPPER_OK(pgok), .I_PG_LOWER_OK(pgok), .O_HIGH_SIDE_GATE(hs),
    .O_LOW_SIDE_GATE_DRIVE(ls), .O_ZC_ENABLE(zce), .O_INTEGRATOR_EN(integ), .O_OVP_HOLD_1V85(ovp),
    .O_TARGET(target), .O_CORE_TWO_PHASE(two_ph), .O_DISCHARGE_CORE(dis_core), .O_DISCHARGE_NB(dis_nb),
    .O_CORE_IDLE_THRESH(core_th), .O_NB_IDLE_THRESH(nb_th), .O_POWER_GOOD_OUTPUT_O(pg_o),
    .O_POWER_GOOD_OUTPUT_OE(pg_oe), .O_IRQ(irq));
  vid_plant #(.SW_DIV(16)) i_plant (.i_clk(clk), .i_resetn(resetn), .i_high_gate(hs), .o_sw_clk(swc),
    .o_fb_above(fb), .o_cs_idle(csi), .o_zero_cross(zc), .o_err_cmp(errc), .o_pg_ok(pgok));

  // ****************************
  // Helpers
  // ****************************
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function int fin(input int c);
    return (c >= 'h7c) ? 0 : 3100 - 25 * c;
  endfunction
  function int sl(input int u, input int r);
    return u * 2 * r / 715;
  endfunction
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task near(input string nm, input int s, input int e);
    chk(nm, (s >= e - e / 50 - 3 && s <= e + e / 50 + 3) ? e : s, e);
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= wd;
    @(posedge clk);
    while (waitreq)
      @(posedge clk);
    d = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wait_tgt(input int i, input int t);
    cyc = 0;
    while (target[i * 12 +: 12] !== 12'(t))
    begin
      @(posedge clk);
      cyc++;
    end
  endtask
  task conclude();
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude();
  end

  // ****************************
  // Scenarios
  // ****************************
  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 0; a < 16; a++)
    begin
      bus(1'b0, a[3:0], 32'h0);
      if (a != 6)
        chk("reset value", d, (a < 3) ? 32'h7f : (a == 4) ? 32'h8f : 32'h0);
    end
    bus(1'b1, 4'hc, 32'hffffffff);
    bus(1'b0, 4'hc, 32'h0);
    chk("unmapped", d, 32'h0);
    for (int k = 0; k < 6; k++)
    begin
      v = rnd();
      bus(1'b1, 4'(k % 3), {25'h0, v[6:0]});
      bus(1'b0, 4'(k % 3), 32'h0);
      chk("code readback", d, {25'h0, v[6:0]});
      bus(1'b1, 4'h5, {16'h0, v[23:8]});
      tick(1);
      chk("core idle", core_th, v[15:8] * 15 / 100);
      chk("nb idle", nb_th, v[23:16] * 25 / 100);
    end
    for (int i = 0; i < 3; i++)
      bus(1'b1, i[3:0], 32'h78);
    bus(1'b1, 4'h4, 32'd357);
    bus(1'b1, 4'h3, 32'h1);
    tick(2);
    chk("soft skip", zce, 3'b111);
    wait_tgt(0, fin('h78));
    near("soft time", cyc, fin('h78) * 25);
    tick(4);
    bus(1'b1, 4'h3, 32'h53);
    tick(2);
    chk("mode per output", zce, 3'b010);
    bus(1'b1, 4'h0, 32'h70);
    wait_tgt(0, fin('h70));
    near("up time", cyc, sl(fin('h70) - fin('h78), 357));
    bus(1'b0, 4'h6, 32'h0);
    chk("blanked", d[0], 1'b1);
    tick(985);
    bus(1'b0, 4'h6, 32'h0);
    chk("still blanked", d[0], 1'b1);
    tick(15);
    bus(1'b0, 4'h6, 32'h0);
    chk("unblanked", d[0], 1'b0);
    chk("power good", pg_oe, 1'b0);
    chk("power good level", pg_o, 1'b0);
    bus(1'b1, 4'h8, 32'h1);
    tick(2);
    chk("irq raised", irq, 1'b1);
    bus(1'b1, 4'h8, 32'h0);
    tick(2);
    chk("irq masked", irq, 1'b0);
    bus(1'b1, 4'h8, 32'h1);
    bus(1'b1, 4'h9, 32'h1);
    tick(2);
    chk("irq cleared", irq, 1'b0);
    bus(1'b1, 4'h4, 32'd3570);
    bus(1'b1, 4'h0, 32'h74);
    wait_tgt(0, fin('h74));
    near("down time", cyc, sl(fin('h70) - fin('h74), 3570));
    chk("ovp held", ovp[0], 1'b1);
    bus(1'b0, 4'h6, 32'h0);
    chk("upper blanked", d[0], 1'b1);
    in_reg <= 3'b111;
    tick(8);
    chk("ovp released", ovp[0], 1'b0);
    bus(1'b0, 4'h6, 32'h0);
    chk("upper enabled", d[0], 1'b0);
    bus(1'b1, 4'h1, 32'h7a);
    tick(3);
    chk("integrator off", integ[1], 1'b0);
    wait_tgt(1, fin('h7a));
    tick(2);
    bus(1'b1, 4'h1, 32'h7a);
    bus(1'b0, 4'h6, 32'h0);
    chk("same code idle", d[10], 1'b0);
    bus(1'b1, 4'h2, 32'h79);
    bus(1'b0, 4'h6, 32'h0);
    chk("new code slews", d[16], 1'b1);
    bus(1'b1, 4'h3, 32'h17);
    tick(2);
    chk("two phase", two_ph, 1'b1);
    bus(1'b1, 4'h3, 32'h07);
    tick(2);
    chk("one phase", {two_ph, zce[0]}, 2'b01);
    bus(1'b1, 4'h3, 32'h0);
    tick(2);
    chk("discharge", {dis_core, dis_nb}, 3'b111);
    conclude();
  end
endmodule
`default_nettype wire
